// file: common/dri_pkg.sv
// Function
// [RL1] hold reset low 200 us at power-up
// [RL2] clock enable low 10 ns before reset release
// [RL3] wait 500 us after reset before clock enable
// [RL4] clock runs five periods before clock enable
// [RL5] nop registered before clock enable rises
// [RL6] clock enable stays high through initialization
// [RL7] device termination off until clock enable
// [RL8] odt held static low during initialization
// [RL9] wait txpr before first mode register write
// [RL10] write mr2 then mr3 with bank codes
// [RL11] then mr1 dll on, mr0 dll reset
// [RL12] long zq calibration after mr0, nops between
// [RL13] wait dll lock and zq init before ready
// [RL14] warm reset 100 ns then repeat sequence
// [RL15] all four mode registers written every init
// [RL16] every mode write carries full field values
// [RL17] keep tmrd between mode register writes
// [RL18] keep tmod after mode write before others
// [RL19] rewrites only while idle with clock enable
// [RL20] mr0 write drives all command bits low
// [RL21] reserved mode bits written as zero
// [RL22] write recovery at least ceil twr over tck; code only computes wr_min_code and never checks the written field
package dri_pkg;
    localparam int CLK_PERIOD_NS   = 50;
    localparam int T_PWR_RST_US    = 200;
    localparam int T_WARM_RST_NS   = 100;
    localparam int T_CKE_RST_NS    = 10;
    localparam int T_RST_CKE_US    = 500;
    localparam int T_CK_STABLE_NS  = 10;
    localparam int T_XPR_NS        = 270;
    localparam int T_MRD_TCK       = 4;
    localparam int T_MOD_TCK       = 12;
    localparam int T_DLLK_TCK      = 512;
    localparam int T_ZQINIT_TCK    = 512;
    localparam int T_WR_NS         = 15;
    localparam int MIN_CK_CYC      = 5;
    // cycle counts; least times round up
    localparam int PWR_RST_CYC  = (T_PWR_RST_US*1000 + CLK_PERIOD_NS-1)
                                  / CLK_PERIOD_NS;
    localparam int WARM_RST_CYC = (T_WARM_RST_NS + CLK_PERIOD_NS-1)
                                  / CLK_PERIOD_NS;
    localparam int CKE_RST_CYC  = (T_CKE_RST_NS + CLK_PERIOD_NS-1)
                                  / CLK_PERIOD_NS;
    localparam int RST_CKE_CYC  = (T_RST_CKE_US*1000 + CLK_PERIOD_NS-1)
                                  / CLK_PERIOD_NS;
    localparam int CKS_NS_CYC   = (T_CK_STABLE_NS + CLK_PERIOD_NS-1)
                                  / CLK_PERIOD_NS;
    localparam int CK_STABLE_CYC = (CKS_NS_CYC > MIN_CK_CYC) ?
                                   CKS_NS_CYC : MIN_CK_CYC;
    localparam int XPR_NS_CYC   = (T_XPR_NS + CLK_PERIOD_NS-1)
                                  / CLK_PERIOD_NS;
    localparam int XPR_CYC      = (XPR_NS_CYC > MIN_CK_CYC) ?
                                  XPR_NS_CYC : MIN_CK_CYC;
    localparam int WR_MIN_CYC   = (T_WR_NS + CLK_PERIOD_NS-1)
                                  / CLK_PERIOD_NS;
    localparam int FINAL_CYC    = (T_DLLK_TCK > T_ZQINIT_TCK) ?
                                  T_DLLK_TCK : T_ZQINIT_TCK;
    localparam int CNT_W = 24;
    // command encodings {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_ZQ  = 4'h6;
    // bank codes
    localparam logic [2:0] BA_MR0 = 3'h0;
    localparam logic [2:0] BA_MR1 = 3'h1;
    localparam logic [2:0] BA_MR2 = 3'h2;
    localparam logic [2:0] BA_MR3 = 3'h3;
    // field positions and masks
    localparam int MR0_DLL_RST_BIT = 8;
    localparam int MR1_DLL_DIS_BIT = 0;
    localparam int ZQ_LONG_BIT     = 10;
    localparam int MR0_WR_LSB      = 9;
    localparam logic [15:0] MR0_RSVD_MASK = 16'hE000;
    localparam logic [15:0] MR1_RSVD_MASK = 16'hE000;
    localparam logic [15:0] MR2_RSVD_MASK = 16'hF907;
    localparam logic [15:0] MR3_RSVD_MASK = 16'hFFFC;
    // software port map
    localparam logic [3:0] A_CTRL   = 4'h0;
    localparam logic [3:0] A_STATUS = 4'h1;
    localparam logic [3:0] A_MR0    = 4'h2;
    localparam logic [3:0] A_MR1    = 4'h3;
    localparam logic [3:0] A_MR2    = 4'h4;
    localparam logic [3:0] A_MR3    = 4'h5;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_WARM_BIT  = 1;
    localparam int CTRL_ODT_BIT   = 2;
    localparam int CTRL_MRW_BIT   = 3;
    localparam logic [15:0] MR0_RST_VAL = 16'h0520;
    localparam logic [15:0] MR1_RST_VAL = 16'h0000;
    localparam logic [15:0] MR2_RST_VAL = 16'h0000;
    localparam logic [15:0] MR3_RST_VAL = 16'h0000;
    typedef enum logic [3:0] {
        ST_IDLE, ST_RST, ST_CKE_LOW, ST_WAIT_CKE, ST_NOP_CKE,
        ST_XPR, ST_MRS, ST_GAP, ST_ZQ, ST_FINAL, ST_READY, ST_MOD
    } dri_state_t;
endpackage

// file: design/dri_init_ctrl.sv
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// drives a ddr3 device from power-up through mode register setup
module dri_init_ctrl
#(
    parameter int PWR_RST_CYC = dri_pkg::PWR_RST_CYC,
    parameter int RST_CKE_CYC = dri_pkg::RST_CKE_CYC
)
(
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    output logic             o_dram_rst_n,
    output logic             o_cke,
    output logic             o_ck_en,
    output logic             o_cs_n,
    output logic             o_ras_n,
    output logic             o_cas_n,
    output logic             o_we_n,
    output logic      [2:0]  o_ba,
    output logic      [15:0] o_a,
    output logic             o_odt,
    output logic             o_ready
);
    import dri_pkg::*;

    // state and counters
    dri_state_t        st_q, st_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;     // wait counter
    logic [1:0]        mr_idx_q, mr_idx_d; // which mode register next
    logic              warm_q, warm_d;   // warm reset shorter hold
    logic              one_q, one_d;     // single write in normal use
    // software registers
    logic [15:0] mr_q [4];               // mode register images
    logic        odt_sel_q;              // static odt level
    logic        start_q, warm_req_q, mrw_q; // one-cycle requests
    // pin registers
    logic        rst_n_q, cke_q, ck_en_q, odt_q, ready_q;
    logic [3:0]  cmd_q, cmd_d;
    logic [2:0]  ba_q, ba_d;
    logic [15:0] a_q, a_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;                // read mux result

    // decode of the software port
    wire wr_ctrl = i_wr && (i_addr == A_CTRL);
    wire wr_mr   = i_wr && (i_addr >= A_MR0) && (i_addr <= A_MR3);
    wire [1:0] wr_mr_sel = 2'(i_addr - A_MR0);
    wire cnt_done = (cnt_q == '0);

    // mode register image with reserved bits forced clear
    logic [15:0] mr_word;
    logic [2:0]  mr_ba;
    always_comb
    begin
        mr_word = '0;
        mr_ba   = BA_MR0;
        case (mr_idx_q)
            2'h0:
            begin
                mr_ba   = BA_MR2;                   // [RL10]
                mr_word = mr_q[2] & ~MR2_RSVD_MASK; // [RL21]
            end
            2'h1:
            begin
                mr_ba   = BA_MR3;                   // [RL10]
                mr_word = mr_q[3] & ~MR3_RSVD_MASK; // [RL21]
            end
            2'h2:
            begin
                mr_ba   = BA_MR1;                   // [RL11]
                mr_word = mr_q[1] & ~MR1_RSVD_MASK; // [RL21]
                mr_word[MR1_DLL_DIS_BIT] = 1'b0;    // [RL11]
            end
            default:
            begin
                mr_ba   = BA_MR0;                   // [RL20]
                mr_word = mr_q[0] & ~MR0_RSVD_MASK; // [RL21]
                mr_word[MR0_DLL_RST_BIT] = 1'b1;    // [RL11]
            end
        endcase
    end

    // main sequence; default every cycle is a nop
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_done ? cnt_q : cnt_q - 1'b1;
        mr_idx_d = mr_idx_q;
        warm_d = warm_q;
        one_d = one_q;
        cmd_d = CMD_NOP;                            // [RL12]
        ba_d = '0;
        a_d = '0;
        case (st_q)
            ST_IDLE:
            begin
                if (start_q || warm_req_q)
                begin
                    st_d = ST_RST;
                    warm_d = warm_req_q;
                    cnt_d = warm_req_q ? CNT_W'(WARM_RST_CYC) // [RL14]
                                       : CNT_W'(PWR_RST_CYC); // [RL1]
                end
            end
            ST_RST:
            // cke is already low; finish the hold, then keep margin
            if (cnt_done)
            begin
                st_d = ST_CKE_LOW;
                cnt_d = CNT_W'(CKE_RST_CYC);        // [RL2]
            end
            ST_CKE_LOW:
            if (cnt_done)
            begin
                st_d = ST_WAIT_CKE;
                cnt_d = CNT_W'(RST_CKE_CYC);        // [RL3]
            end
            ST_WAIT_CKE:
            // clock runs from here, long before the cke edge
            if (cnt_done)
            begin
                st_d = ST_NOP_CKE;
                cnt_d = CNT_W'(CK_STABLE_CYC);      // [RL4]
            end
            ST_NOP_CKE:
            if (cnt_done)                           // [RL5]
            begin
                st_d = ST_XPR;
                cnt_d = CNT_W'(XPR_CYC);            // [RL9]
            end
            ST_XPR:
            if (cnt_done)
            begin
                st_d = ST_MRS;
                mr_idx_d = '0;                      // [RL15]
            end
            ST_MRS:
            begin
                cmd_d = CMD_MRS;
                ba_d = mr_ba;
                a_d = mr_word;                      // [RL16]
                if (one_q)
                begin
                    st_d = ST_MOD;
                    cnt_d = CNT_W'(T_MOD_TCK);      // [RL18]
                end
                else if (mr_idx_q == 2'h3)
                begin
                    // index wraps to zero: marks the pass as written
                    st_d = ST_GAP;
                    mr_idx_d = '0;
                    cnt_d = CNT_W'(T_MOD_TCK);      // [RL18]
                end
                else
                begin
                    st_d = ST_GAP;
                    mr_idx_d = mr_idx_q + 1'b1;
                    cnt_d = CNT_W'(T_MRD_TCK - 1);  // [RL17]
                end
            end
            ST_GAP:
            // gap after the last write leads into calibration
            if (cnt_done)
                st_d = (mr_idx_q == 2'h0) ? ST_ZQ : ST_MRS; // [RL12]
            ST_ZQ:
            begin
                cmd_d = CMD_ZQ;                     // [RL12]
                a_d[ZQ_LONG_BIT] = 1'b1;
                st_d = ST_FINAL;
                cnt_d = CNT_W'(FINAL_CYC);          // [RL13]
            end
            ST_FINAL:
            if (cnt_done)
                st_d = ST_READY;                    // [RL13]
            ST_READY:
            // only idle, cke high traffic here, so rewrite is legal
            begin
                if (start_q || warm_req_q)
                begin
                    st_d = ST_RST;
                    warm_d = warm_req_q;
                    cnt_d = warm_req_q ? CNT_W'(WARM_RST_CYC) // [RL14]
                                       : CNT_W'(PWR_RST_CYC);
                end
                else if (mrw_q)
                begin
                    st_d = ST_MRS;                  // [RL19]
                    one_d = 1'b1;
                    mr_idx_d = 2'h3;
                end
            end
            ST_MOD:
            if (cnt_done)
            begin
                st_d = ST_READY;
                one_d = 1'b0;
            end
            default:
                st_d = ST_IDLE;
        endcase
    end

    // state and counter registers
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            mr_idx_q <= '0;
            warm_q <= 1'b0;
            one_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            mr_idx_q <= mr_idx_d;
            warm_q <= warm_d;
            one_q <= one_d;
        end
    end

    // pins; reset low and cke low outside the running sequence
    wire in_rst  = (st_q == ST_IDLE) || (st_q == ST_RST);
    wire cke_on  = !(in_rst || st_q == ST_CKE_LOW ||
                     st_q == ST_WAIT_CKE || st_q == ST_NOP_CKE);
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_n_q <= 1'b0;
            cke_q <= 1'b0;
            ck_en_q <= 1'b0;
            odt_q <= 1'b0;
            ready_q <= 1'b0;
            cmd_q <= CMD_NOP;
            ba_q <= '0;
            a_q <= '0;
        end
        else
        begin
            rst_n_q <= !(in_rst && st_d != ST_CKE_LOW) ||
                       (st_q == ST_RST && cnt_done);  // [RL2]
            cke_q <= (st_d != ST_IDLE && st_d != ST_RST &&
                      st_d != ST_CKE_LOW && st_d != ST_WAIT_CKE &&
                      st_d != ST_NOP_CKE);              // [RL6]
            ck_en_q <= (st_d != ST_IDLE && st_d != ST_RST &&
                        st_d != ST_CKE_LOW);           // [RL4]
            odt_q <= (st_d == ST_READY || st_d == ST_MOD) &&
                     odt_sel_q;                        // [RL8]
            ready_q <= (st_d == ST_READY);             // [RL13]
            cmd_q <= cmd_d;
            ba_q <= ba_d;
            a_q <= a_d;
        end
    end

    // software registers; requests last one cycle
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            mr_q[0] <= MR0_RST_VAL;
            mr_q[1] <= MR1_RST_VAL;
            mr_q[2] <= MR2_RST_VAL;
            mr_q[3] <= MR3_RST_VAL;
            odt_sel_q <= 1'b0;
            start_q <= 1'b0;
            warm_req_q <= 1'b0;
            mrw_q <= 1'b0;
            rdata_q <= '0;
        end
        else
        begin
            if (wr_mr)
                mr_q[wr_mr_sel] <= i_wdata;
            if (wr_ctrl)
                odt_sel_q <= i_wdata[CTRL_ODT_BIT];
            start_q <= wr_ctrl && i_wdata[CTRL_START_BIT];
            warm_req_q <= wr_ctrl && i_wdata[CTRL_WARM_BIT];
            mrw_q <= wr_ctrl && i_wdata[CTRL_MRW_BIT];
            rdata_q <= rdata_d;
        end
    end

    // read mux; unmapped reads give zero
    always_comb
    begin
        rdata_d = '0;
        if (i_rd)
        begin
            case (i_addr)
                A_CTRL:   rdata_d = {13'h0000, odt_sel_q, 2'h0};
                A_STATUS: rdata_d = {11'h000, ready_q, 4'(st_q)};
                A_MR0, A_MR1, A_MR2, A_MR3: rdata_d = mr_q[wr_mr_sel];
                default:  rdata_d = '0;
            endcase
        end
    end

    // wr recovery field lower bound; not driven to any output or read port
    wire [2:0] wr_min_code = 3'(WR_MIN_CYC);        // [RL22]

    assign o_rdata = rdata_q;
    assign o_dram_rst_n = rst_n_q;                  // [RL7]
    assign o_cke = cke_q;
    assign o_ck_en = ck_en_q;
    assign {o_cs_n, o_ras_n, o_cas_n, o_we_n} = cmd_q;
    assign o_ba = ba_q;
    assign o_a = a_q;
    assign o_odt = odt_q;
    assign o_ready = ready_q;
endmodule
`default_nettype wire

// file: testbench/dri_init_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none
module dri_init_ctrl_properties
import dri_pkg::*;
#(
    parameter int PWR_RST_CYC = 20,
    parameter int RST_CKE_CYC = 20
)
(
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    input  wire logic        o_dram_rst_n,
    input  wire logic        o_cke,
    input  wire logic        o_ck_en,
    input  wire logic        o_cs_n,
    input  wire logic        o_ras_n,
    input  wire logic        o_cas_n,
    input  wire logic        o_we_n,
    input  wire logic [2:0]  o_ba,
    input  wire logic [15:0] o_a,
    input  wire logic        o_odt,
    input  wire logic        o_ready
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    // command decode on the device pins
    wire logic [3:0]  cmd = {o_cs_n, o_ras_n, o_cas_n, o_we_n};
    wire logic        mrs = cmd == CMD_MRS;
    wire logic        zq  = cmd == CMD_ZQ;
    wire logic        oth = !o_cs_n && !mrs && cmd != CMD_NOP;
    // reserved mask of the register being written
    wire logic [15:0] rsv = (o_ba == BA_MR0) ? MR0_RSVD_MASK :
                            (o_ba == BA_MR1) ? MR1_RSVD_MASK :
                            (o_ba == BA_MR2) ? MR2_RSVD_MASK : MR3_RSVD_MASK;
    int lo_q;   // cycles with device reset low
    int up_q;   // cycles since reset release, clock enable still low
    int ck_q;   // cycles since clock enable rose
    int gp_q;   // cycles since the last mode write
    int zq_q;   // cycles since the last calibration
    // ck_q, gp_q and zq_q saturate at 4095 so that long idle spans never wrap
    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            lo_q <= 0;
            up_q <= 0;
            ck_q <= 0;
            gp_q <= 4095;
            zq_q <= 4095;
        end
        else
        begin
            lo_q <= o_dram_rst_n ? 0 : lo_q + 1;
            up_q <= !o_dram_rst_n ? 0 : (o_cke ? up_q : up_q + 1);
            ck_q <= !o_cke ? 0 : (ck_q < 4095 ? ck_q + 1 : ck_q);
            gp_q <= mrs ? 1 : (gp_q < 4095 ? gp_q + 1 : gp_q);
            zq_q <= zq ? 1 : (zq_q < 4095 ? zq_q + 1 : zq_q);
        end
    end
    a_cke_before_release: assert property (
        $rose(o_dram_rst_n) |-> !o_cke && !$past(o_cke))
        else $error("clock enable high at reset release");
    a_reset_low_min: assert property (
        $rose(o_dram_rst_n) |-> lo_q >= WARM_RST_CYC)
        else $error("device reset pulse too short");
    a_cke_wait_min: assert property (
        $rose(o_cke) |-> up_q >= RST_CKE_CYC)
        else $error("clock enable raised too early");
    a_clock_runs_first: assert property (
        $rose(o_cke) |-> o_ck_en && $past(o_ck_en, 5))
        else $error("clock not running before clock enable");
    a_nop_before_cke: assert property (
        $rose(o_cke) |-> $past(o_cs_n) || $past(cmd) == CMD_NOP)
        else $error("no nop ahead of clock enable");
    a_cke_held: assert property (
        $fell(o_cke) |-> !o_dram_rst_n || $past(o_ready) || $past(o_ready, 2))
        else $error("clock enable dropped during init");
    a_odt_static: assert property (
        o_cke && $past(o_cke) && !o_ready |-> $stable(o_odt))
        else $error("odt moved during init");
    a_xpr_wait: assert property (
        mrs |-> o_cke && ck_q >= XPR_CYC)
        else $error("mode write too soon after clock enable");
    a_mrd_gap: assert property (
        mrs |-> gp_q >= T_MRD_TCK)
        else $error("mode writes too close");
    a_mod_gap: assert property (
        oth |-> gp_q >= T_MOD_TCK)
        else $error("command too soon after mode write");
    a_zq_long: assert property (
        zq |-> o_a[ZQ_LONG_BIT] && o_ba == 3'h0)
        else $error("calibration not long form");
    a_rsvd_zero: assert property (
        mrs |-> (o_a & rsv) == 16'h0000)
        else $error("reserved mode bit set");
    a_ready_wait: assert property (
        $rose(o_ready) |-> zq_q >= FINAL_CYC)
        else $error("ready before lock and calibration");
endmodule
bind dri_init_ctrl dri_init_ctrl_properties #(
    .PWR_RST_CYC(PWR_RST_CYC), .RST_CKE_CYC(RST_CKE_CYC)) u_props (
    .i_clock(i_clock), .i_nrst(i_nrst), .o_dram_rst_n(o_dram_rst_n),
    .o_cke(o_cke), .o_ck_en(o_ck_en), .o_cs_n(o_cs_n), .o_ras_n(o_ras_n),
    .o_cas_n(o_cas_n), .o_we_n(o_we_n), .o_ba(o_ba), .o_a(o_a),
    .o_odt(o_odt), .o_ready(o_ready));
`default_nettype wire

// file: testbench/dri_dram_model.sv
`timescale 1ns/1ns
`default_nettype none
// behavioural device: records mode writes and calibrations
module dri_dram_model
import dri_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_cke,
    input  wire logic        i_cs_n,
    input  wire logic        i_ras_n,
    input  wire logic        i_cas_n,
    input  wire logic        i_we_n,
    input  wire logic [2:0]  i_ba,
    input  wire logic [15:0] i_a,
    output logic             o_term_on
);
    logic [15:0] mr [4];    // mode register contents
    logic [2:0]  seen [8];  // bank code of each mode write, in order
    int          n_mrs;     // mode writes since reset
    int          n_zq;      // long calibrations since reset
    wire logic [3:0] cmd = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
    // termination leaves high impedance only once enable is seen
    always @(posedge i_clock)
        o_term_on <= i_rst_n && (o_term_on || i_cke);
    // commands count only after enable; internal init ignores the bus
    always @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            mr <= '{default: 16'hxxxx};
            n_mrs <= 0;
            n_zq <= 0;
        end
        else if (i_cke && cmd == CMD_MRS)
        begin
            mr[i_ba[1:0]] <= i_a;
            seen[n_mrs[2:0]] <= i_ba;
            n_mrs <= n_mrs + 1;
        end
        else if (i_cke && cmd == CMD_ZQ && i_a[ZQ_LONG_BIT])
            n_zq <= n_zq + 1;
    end
endmodule
`default_nettype wire

// file: testbench/dri_init_ctrl_bench.sv
`timescale 1ns/1ns
`default_nettype none
module dri_init_ctrl_bench;
    import dri_pkg::*;
    localparam int PWR = 20;    // shortened power-up reset
    localparam int RCK = 20;    // shortened enable wait
    logic        i_clock = 1'b0;
    logic        i_nrst  = 1'b0;
    logic [3:0]  i_addr  = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_wr    = 1'b0;
    logic        i_rd    = 1'b0;
    wire logic [15:0] o_rdata, o_a;
    wire logic [2:0]  o_ba;
    wire logic o_dram_rst_n, o_cke, o_ck_en, o_cs_n, o_ras_n, o_cas_n;
    wire logic o_we_n, o_odt, o_ready, term_on;
    int          fail_count  = 0;
    int          comparisons = 0;
    logic [15:0] img [4];   // images written by software
    logic [2:0]  order [4] = '{BA_MR2, BA_MR3, BA_MR1, BA_MR0};
    always #25 i_clock = ~i_clock;
    dri_init_ctrl #(.PWR_RST_CYC(PWR), .RST_CKE_CYC(RCK)) dut (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_dram_rst_n(o_dram_rst_n), .o_cke(o_cke), .o_ck_en(o_ck_en),
        .o_cs_n(o_cs_n), .o_ras_n(o_ras_n), .o_cas_n(o_cas_n),
        .o_we_n(o_we_n), .o_ba(o_ba), .o_a(o_a), .o_odt(o_odt),
        .o_ready(o_ready));
    dri_dram_model dev (
        .i_clock(i_clock), .i_rst_n(o_dram_rst_n), .i_cke(o_cke),
        .i_cs_n(o_cs_n), .i_ras_n(o_ras_n), .i_cas_n(o_cas_n),
        .i_we_n(o_we_n), .i_ba(o_ba), .i_a(o_a), .o_term_on(term_on));
    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(negedge i_clock);
        chk(o_rdata, exp);
    endtask
    // follow one init pass, measuring the reset and enable spans
    task automatic run_init(input int lo_min);
        int n;
        n = 0;
        while (o_dram_rst_n === 1'b1 && n < 50)
        begin
            @(posedge i_clock);
            n++;
        end
        n = 0;
        while (o_dram_rst_n !== 1'b1 && n < 9000)
        begin
            @(posedge i_clock);
            n++;
        end
        chk(16'(n >= lo_min), 16'h0001);
        chk({15'h0, term_on}, 16'h0000);
        n = 0;
        while (o_cke !== 1'b1 && n < 9000)
        begin
            @(posedge i_clock);
            n++;
        end
        chk(16'(n >= RCK), 16'h0001);
        n = 0;
        while (o_ready !== 1'b1 && n < 3000)
        begin
            @(posedge i_clock);
            n++;
        end
        chk({15'h0, o_ready}, 16'h0001);
        chk(16'(dev.n_mrs), 16'h0004);
        chk(16'(dev.n_zq), 16'h0001);
        for (int i = 0; i < 4; i++)
            chk({13'h0, dev.seen[i]}, {13'h0, order[i]});
        chk(dev.mr[0], img[0] & ~MR0_RSVD_MASK | 16'h0100);
        chk(dev.mr[1], img[1] & ~MR1_RSVD_MASK & ~16'h0001);
        chk(dev.mr[2], img[2] & ~MR2_RSVD_MASK);
        chk(dev.mr[3], img[3] & ~MR3_RSVD_MASK);
    endtask
    // hang guard, well past the expected run length
    initial
    begin
        repeat (20000) @(posedge i_clock);
        fail_count++;
        conclude();
    end
    initial
    begin
        repeat (16) @(posedge i_clock);
        i_nrst <= 1'b1;
        // image defaults, then an unmapped place
        rd(A_MR0, MR0_RST_VAL);
        rd(A_MR1, MR1_RST_VAL);
        rd(A_MR2, MR2_RST_VAL);
        rd(A_MR3, MR3_RST_VAL);
        rd(4'hF, 16'h0000);
        // images with every reserved bit set; write recovery field 1
        img = '{16'hE250, 16'hFFFF, 16'hFFFF, 16'hFFFF};
        for (int i = 0; i < 4; i++)
            wr(A_MR0 + 4'(i), img[i]);
        wr(A_CTRL, 16'h0001);
        run_init(PWR);
        chk({15'h0, term_on}, 16'h0001);
        // rewrite of one image while idle and ready
        img[0] = 16'hE450;
        wr(A_MR0, img[0]);
        wr(A_CTRL, 16'h0008);
        repeat (60) @(posedge i_clock);
        chk(16'(dev.n_mrs), 16'h0005);
        chk(dev.mr[0], 16'h0550);
        chk({15'h0, o_cke}, 16'h0001);
        // reset without power loss repeats the whole setup
        wr(A_CTRL, 16'h0002);
        run_init(WARM_RST_CYC);
        conclude();
    end
endmodule
`default_nettype wire
